// [logic/clm_consts.vh]
// constants for the coding-layer management register bank
// assumes a 16-bit register address already selected to the third memory map
`ifndef CLM_CONSTS_VH
`define CLM_CONSTS_VH

// register addresses (16-bit register index)
`define CLM_ADDR_DEV_PKG_LO   16'h0005
`define CLM_ADDR_DEV_PKG_HI   16'h0006
`define CLM_ADDR_EXT_ABILITY  16'h0012
`define CLM_ADDR_CTRL         16'h08f3
`define CLM_ADDR_STATUS       16'h08f4
`define CLM_ADDR_FAR_BABBLE   16'h08f5
`define CLM_ADDR_WIRE_OVERLAP 16'h08f6

// field positions
`define CLM_CTRL_RESET_BIT    15
`define CLM_CTRL_LOOP_BIT     14
`define CLM_STAT_FAULT_BIT    7

// constant register contents
`define CLM_DEV_PKG_LO_VAL    16'h000b
`define CLM_DEV_PKG_HI_VAL    16'h0000
`define CLM_EXT_ABILITY_VAL   16'h0008

// reset values and tally saturation limit
`define CLM_CTRL_RST          16'h0000
`define CLM_CNT_RST           16'h0000
`define CLM_CNT_MAX           16'hffff

// cycles the internal soft reset is held
`define CLM_SOFT_RST_CYCLES   4

`endif

// [logic/clm_regs.v]
// coding-layer management registers: control, status, diagnostics, capability
// assumes one register access per cycle strobe from the spi register engine,
// and event pulses from coding-layer logic on the same clock
`include "clm_consts.vh"

// Overview of operation
// - writing soft reset bit restores defaults; bit self-clears when reset ends
// - soft reset drives reset of both coding and medium attachment layers
// - soft reset may drop link; link logic may restart after it
// - loopback bit routes mac frames through coding tx then rx paths
// - loopback covers 4b/5b coder, tx/rx state machines and scrambler
// - fault bit sets on any local or remote jabber detection
// - fault bit stays latched until status read, read clears it
// - 16-bit remote jabber tally counts since last read, read clears
// - remote jabber tally saturates at ffff
// - 16-bit collision tally counts physical collisions, read clears
// - collision tally saturates at ffff
// - logical arbitration collisions are not counted
// - devices-in-package low reads bits 3,1,0 set, rest zero
// - extended ability reads bit 3 set only
// - all registers are 16 bits wide
// - upper two bytes of 32-bit access read zero, writes ignored
module clm_regs #(
  parameter SOFT_RST_CYCLES = `CLM_SOFT_RST_CYCLES
) (
  input  wire        mclk_in,
  input  wire        rst_b_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [15:0] reg_addr_in,
  input  wire [31:0] reg_wdata_in,
  output reg  [31:0] reg_rdata_out,
  input  wire        local_jabber_in,
  input  wire        remote_jabber_in,
  input  wire        collision_in,
  input  wire        collision_logical_in,
  output wire        coding_layer_rst_out,
  output wire        medium_attach_rst_out,
  output wire        loopback_out
);

  reg        soft_rst_r;
  reg        loopback_r;
  reg        fault_r;
  reg [15:0] far_babble_tally_r;
  reg [15:0] wire_overlap_tally_r;
  reg [7:0]  rst_cnt_r;
  reg [15:0] rd_val;

  wire wr_ctrl   = reg_wr_in && (reg_addr_in == `CLM_ADDR_CTRL);
  wire rd_status = reg_rd_in && (reg_addr_in == `CLM_ADDR_STATUS);
  wire rd_babble = reg_rd_in && (reg_addr_in == `CLM_ADDR_FAR_BABBLE);
  wire rd_ovlap  = reg_rd_in && (reg_addr_in == `CLM_ADDR_WIRE_OVERLAP);
  // a physical overlap only; arbitration collisions are filtered out
  wire ovlap_evt = collision_in && !collision_logical_in;

  // saturating count with read-clear; an event in the read cycle starts the new count
  function [15:0] tally_next;
    input [15:0] cur;
    input        rd;
    input        evt;
    begin
      if (rd) begin
        tally_next = evt ? 16'h0001 : `CLM_CNT_RST;
      end else if (evt && cur != `CLM_CNT_MAX) begin
        tally_next = cur + 16'h0001;
      end else begin
        tally_next = cur;
      end
    end
  endfunction

  // soft reset: held for a fixed count, then the bit clears itself
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      soft_rst_r <= 1'b0;
      rst_cnt_r  <= 8'h00;
    end else if (soft_rst_r) begin
      if (rst_cnt_r == SOFT_RST_CYCLES[7:0] - 8'h01) begin
        soft_rst_r <= 1'b0;
        rst_cnt_r  <= 8'h00;
      end else begin
        rst_cnt_r <= rst_cnt_r + 8'h01;
      end
    end else if (wr_ctrl && reg_wdata_in[`CLM_CTRL_RESET_BIT]) begin
      soft_rst_r <= 1'b1;
    end
  end

  // coding-layer registers return to default under hard or soft reset
  always @(posedge mclk_in) begin
    if (!rst_b_in || soft_rst_r) begin
      loopback_r           <= 1'b0;
      fault_r              <= 1'b0;
      far_babble_tally_r   <= `CLM_CNT_RST;
      wire_overlap_tally_r <= `CLM_CNT_RST;
    end else begin
      // only bit 14 is stored; upper half and other bits are dropped
      if (wr_ctrl) begin
        loopback_r <= reg_wdata_in[`CLM_CTRL_LOOP_BIT];
      end
      // set wins over the read clear
      if (local_jabber_in || remote_jabber_in) begin
        fault_r <= 1'b1;
      end else if (rd_status) begin
        fault_r <= 1'b0;
      end
      far_babble_tally_r   <= tally_next(far_babble_tally_r, rd_babble, remote_jabber_in);
      wire_overlap_tally_r <= tally_next(wire_overlap_tally_r, rd_ovlap, ovlap_evt);
    end
  end

  // both layers held while soft reset runs; link may drop and retrain after
  assign coding_layer_rst_out  = soft_rst_r;
  assign medium_attach_rst_out = soft_rst_r;
  // datapath muxes tx encoder output into rx decoder through the scrambler
  assign loopback_out          = loopback_r;

  // read mux: 16-bit values, everything unused reads zero
  always @* begin
    rd_val = 16'h0000;
    case (reg_addr_in)
      `CLM_ADDR_DEV_PKG_LO:   rd_val = `CLM_DEV_PKG_LO_VAL;
      `CLM_ADDR_DEV_PKG_HI:   rd_val = `CLM_DEV_PKG_HI_VAL;
      `CLM_ADDR_EXT_ABILITY:  rd_val = `CLM_EXT_ABILITY_VAL;
      `CLM_ADDR_CTRL: begin
        rd_val[`CLM_CTRL_RESET_BIT] = soft_rst_r;
        rd_val[`CLM_CTRL_LOOP_BIT]  = loopback_r;
      end
      `CLM_ADDR_STATUS:       rd_val[`CLM_STAT_FAULT_BIT] = fault_r;
      `CLM_ADDR_FAR_BABBLE:   rd_val = far_babble_tally_r;
      `CLM_ADDR_WIRE_OVERLAP: rd_val = wire_overlap_tally_r;
      default:                rd_val = 16'h0000;
    endcase
  end

  // read data registered; captured on the read strobe
  always @(posedge mclk_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= {16'h0000, rd_val};
    end
  end

endmodule

// [test/clm_regs_chk.sv]
// checker for the coding-layer management register bank
// sees only the ports of clm_regs; bound below with the same reset length
module clm_regs_chk #(parameter SOFT_RST_CYCLES = 4) (
  input wire logic        mclk_in, rst_b_in, reg_wr_in, reg_rd_in, local_jabber_in,
  input wire logic        remote_jabber_in, coding_layer_rst_out, medium_attach_rst_out,
  input wire logic        loopback_out,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in, reg_rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  // decoded strobes shared by several properties
  wire jab = local_jabber_in | remote_jabber_in;
  wire st_rd = reg_rd_in && reg_addr_in == 16'h08f4;
  wire ctl_wr = reg_wr_in && reg_addr_in == 16'h08f3;
  property p_pair; coding_layer_rst_out == medium_attach_rst_out; endproperty
  a_pair: assert property (p_pair) else $error("layer resets differ");
  // repetition count is fixed at the default length of 4
  property p_soft; ctl_wr && reg_wdata_in[15] |=> coding_layer_rst_out[*4] ##1
    !coding_layer_rst_out; endproperty
  a_soft: assert property (p_soft) else $error("soft reset length wrong");
  property p_loop; ctl_wr && reg_wdata_in[15:14] == 2'b01 |=> loopback_out; endproperty
  a_loop: assert property (p_loop) else $error("loopback not set");
  property p_up; reg_rdata_out[31:16] == 16'h0000; endproperty
  a_up: assert property (p_up) else $error("upper half not zero");
  property p_dev; reg_rd_in && reg_addr_in == 16'h5 |=> reg_rdata_out == 32'hb; endproperty
  a_dev: assert property (p_dev) else $error("package word wrong");
  property p_ext; reg_rd_in && reg_addr_in == 16'h12 |=> reg_rdata_out == 32'h8; endproperty
  a_ext: assert property (p_ext) else $error("ability word wrong");
  property p_flt; jab && !coding_layer_rst_out ##1 st_rd |=> reg_rdata_out[7]; endproperty
  a_flt: assert property (p_flt) else $error("fault not seen");
  property p_clr; st_rd && !jab ##1 !jab ##1 st_rd |=> !reg_rdata_out[7]; endproperty
  a_clr: assert property (p_clr) else $error("fault not cleared");
endmodule
bind clm_regs clm_regs_chk #(.SOFT_RST_CYCLES(SOFT_RST_CYCLES)) u_chk (.mclk_in, .rst_b_in,
  .reg_wr_in, .reg_rd_in, .local_jabber_in, .remote_jabber_in, .coding_layer_rst_out,
  .medium_attach_rst_out, .loopback_out, .reg_addr_in, .reg_wdata_in, .reg_rdata_out);

// [test/test_clm_regs.sv]
// bench for the coding-layer management register bank
// drives strobes and event pins itself, 1 ns after each rising edge
module test_clm_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_in = 0, rst_b_in = 0, wr = 0, rd = 0, lj = 0, rj = 0, co = 0, cl = 0;
  logic [15:0] addr = 0;
  logic [31:0] wd = 0;
  wire  [31:0] rdat;
  wire         crst, mrst, loop;
  int          n_fail = 0, checks_done = 0;
  // address beside the value it must read; last row is unmapped
  logic [15:0] rows [7][2] = '{'{16'h5, 16'hb}, '{16'h6, 16'h0}, '{16'h12, 16'h8},
    '{16'h8f3, 16'h0}, '{16'h8f5, 16'h0}, '{16'h8f6, 16'h0}, '{16'h100, 16'h0}};
  clm_regs dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdat), .local_jabber_in(lj),
    .remote_jabber_in(rj), .collision_in(co), .collision_logical_in(cl),
    .coding_layer_rst_out(crst), .medium_attach_rst_out(mrst), .loopback_out(loop));
  initial forever #5 mclk_in = ~mclk_in;
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // idle cycle after each access keeps strobes from being set twice in one step
  task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
    {wr, rd, addr, wd} = {w, !w, a, d};
    step();
    {wr, rd} = 2'b00;
    step();
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    acc(0, a, 0);
    chk(rdat, e);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    step(6);
    rst_b_in = 1;
    foreach (rows[k]) rdc(rows[k][0], {16'h0, rows[k][1]});
    $display("register table done");
    acc(1, 16'h8f3, 32'hffff4000);
    chk({31'h0, loop}, 32'h1);
    rdc(16'h8f3, 32'h4000);
    {rj, co} = 2'b11;
    step(2);
    cl = 1;
    step();
    {rj, co, cl} = 3'b000;
    rdc(16'h8f5, 32'h3);
    rdc(16'h8f6, 32'h2);
    lj = 1;
    step();
    lj = 0;
    rdc(16'h8f4, 32'h80);
    rdc(16'h8f4, 32'h0);
    rdc(16'h8f5, 32'h0);
    $display("event tallies done");
    {rj, co} = 2'b11;
    step(65540);
    {rj, co} = 2'b00;
    rdc(16'h8f5, 32'hffff);
    rdc(16'h8f6, 32'hffff);
    acc(1, 16'h8f3, 32'h8000);
    chk({30'h0, crst, mrst}, 32'h3);
    step(4);
    chk({30'h0, crst, loop}, 32'h0);
    rdc(16'h8f4, 32'h0);
    rdc(16'h8f3, 32'h0);
    $display("soft reset done");
    end_sim();
  end
endmodule
